// [design/icm_pkg.sv]
// Constants and carrier types for the interrupt cause mapper
package icm_pkg;

   localparam int ADDR_W    = 8;
   localparam int DATA_W    = 32;
   localparam int NUM_Q     = 4;
   localparam int NUM_VEC   = 5;
   localparam int NUM_ENTRY = 10;
   localparam int LEG_W     = 16;

   // Register byte addresses
   localparam logic [7:0] ADDR_EXT_CAUSE     = 8'h00;
   localparam logic [7:0] ADDR_EXT_CAUSE_SET = 8'h04;
   localparam logic [7:0] ADDR_EXT_MASK_SET  = 8'h08;
   localparam logic [7:0] ADDR_EXT_MASK_CLR  = 8'h0C;
   localparam logic [7:0] ADDR_EXT_AUTO_CLR  = 8'h10;
   localparam logic [7:0] ADDR_EXT_AUTO_MASK = 8'h14;
   localparam logic [7:0] ADDR_LEG_CAUSE     = 8'h18;
   localparam logic [7:0] ADDR_LEG_CAUSE_SET = 8'h1C;
   localparam logic [7:0] ADDR_LEG_MASK_SET  = 8'h20;
   localparam logic [7:0] ADDR_LEG_MASK_CLR  = 8'h24;
   localparam logic [7:0] ADDR_LEG_AUTO_MASK = 8'h28;
   localparam logic [7:0] ADDR_GEN_CONFIG    = 8'h2C;
   localparam logic [7:0] ADDR_QUEUE_ALLOC0  = 8'h30;
   localparam logic [7:0] ADDR_MISC_ALLOC    = 8'h40;

   // Allocation entry layout: two 8-bit entries per register
   localparam int ENTRY_W         = 8;
   localparam int ENTRY_VALID_BIT = 7;
   localparam int ENTRY_IDX_W     = 3;
   localparam int ALLOC_W         = 2 * ENTRY_W;

   // General interrupt configuration fields
   localparam int CFG_NSICR_BIT = 0;
   localparam int CFG_MULTI_BIT = 4;
   localparam int CFG_W         = 5;

   // Fixed extended cause bits in legacy/MSI mode
   localparam int EXT_TIMER_BIT = 30;
   localparam int EXT_OTHER_BIT = 31;
   localparam logic [31:0] EXT_VALID_LEGACY = 32'hC000000F;
   localparam logic [31:0] EXT_VALID_MSIX   = 32'h0000001F;

   localparam logic [31:0] RST_WORD  = 32'h00000000;
   localparam logic [15:0] RST_ALLOC = 16'h0000;
   localparam logic [4:0]  RST_CFG   = 5'h00;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } icm_bus_req_t;

   typedef struct packed {
      logic [NUM_Q-1:0] rx;
      logic [NUM_Q-1:0] tx;
      logic             timer;
      logic [LEG_W-1:0] other;
   } icm_cause_t;

   typedef struct packed {
      logic                   valid;
      logic [ENTRY_IDX_W-1:0] vector;
   } icm_msg_t;

endpackage

// [design/icm_cause_mapper.sv]
// Interrupt cause mapper: cause registers, allocation entries, vector messages
`timescale 1ns/10ps

module icm_cause_mapper (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire icm_pkg::icm_bus_req_t bus_i,
   output logic [icm_pkg::DATA_W-1:0] rdata_o,
   input  wire icm_pkg::icm_cause_t  cause_i,
   input  wire logic                 msg_ack_i,
   output icm_pkg::icm_msg_t         msg_o,
   output logic                      irq_o
);
   import icm_pkg::*;

   // One-hot cause bit for an allocation entry, or zero if disabled/illegal
   function automatic logic [31:0] entry_bit(input logic [ENTRY_W-1:0] ent,
                                             input logic msix);
      logic [31:0] res;
      res = RST_WORD;
      if (ent[ENTRY_VALID_BIT]) begin
         if (msix) begin
            if (int'(ent[ENTRY_IDX_W-1:0]) < NUM_VEC) begin
               res[ent[ENTRY_IDX_W-1:0]] = 1'b1;
            end
         end else begin
            res[ent[1:0]] = 1'b1;
         end
      end
      return res;
   endfunction

   function automatic logic [ENTRY_IDX_W-1:0] lowest(input logic [NUM_VEC-1:0] v);
      logic [ENTRY_IDX_W-1:0] res;
      res = '0;
      for (int i = NUM_VEC - 1; i >= 0; i--) begin
         if (v[i]) begin
            res = ENTRY_IDX_W'(i);
         end
      end
      return res;
   endfunction

   logic [31:0]        ext_cause;
   logic [31:0]        ext_mask;
   logic [31:0]        ext_auto_clr;
   logic [31:0]        ext_auto_mask;
   logic [LEG_W-1:0]   leg_cause;
   logic [LEG_W-1:0]   leg_mask;
   logic [LEG_W-1:0]   leg_auto_mask;
   logic [CFG_W-1:0]   gen_cfg;
   logic [ALLOC_W-1:0] queue_alloc [NUM_Q];
   logic [ALLOC_W-1:0] misc_alloc;
   logic [NUM_VEC-1:0] vec_sent;
   icm_msg_t           msg;
   logic [DATA_W-1:0]  rdata;
   logic               irq;

   logic [31:0]        next_ext_cause;
   logic [31:0]        next_ext_mask;
   logic [LEG_W-1:0]   next_leg_cause;
   logic [LEG_W-1:0]   next_leg_mask;
   logic [NUM_VEC-1:0] next_vec_sent;
   icm_msg_t           next_msg;
   logic [DATA_W-1:0]  rd_mux;

   // Access decode
   wire [DATA_W-1:0] wd = bus_i.wdata;
   wire hit_ecause  = bus_i.addr == ADDR_EXT_CAUSE;
   wire wr_ecause   = bus_i.wr && hit_ecause;
   wire rd_ecause   = bus_i.rd && hit_ecause;
   wire wr_ecset    = bus_i.wr && bus_i.addr == ADDR_EXT_CAUSE_SET;
   wire wr_emset    = bus_i.wr && bus_i.addr == ADDR_EXT_MASK_SET;
   wire wr_emclr    = bus_i.wr && bus_i.addr == ADDR_EXT_MASK_CLR;
   wire wr_eaclr    = bus_i.wr && bus_i.addr == ADDR_EXT_AUTO_CLR;
   wire wr_eamask   = bus_i.wr && bus_i.addr == ADDR_EXT_AUTO_MASK;
   wire hit_lcause  = bus_i.addr == ADDR_LEG_CAUSE;
   wire wr_lcause   = bus_i.wr && hit_lcause;
   wire rd_lcause   = bus_i.rd && hit_lcause;
   wire wr_lcset    = bus_i.wr && bus_i.addr == ADDR_LEG_CAUSE_SET;
   wire wr_lmset    = bus_i.wr && bus_i.addr == ADDR_LEG_MASK_SET;
   wire wr_lmclr    = bus_i.wr && bus_i.addr == ADDR_LEG_MASK_CLR;
   wire wr_lamask   = bus_i.wr && bus_i.addr == ADDR_LEG_AUTO_MASK;
   wire wr_cfg      = bus_i.wr && bus_i.addr == ADDR_GEN_CONFIG;
   wire wr_misc     = bus_i.wr && bus_i.addr == ADDR_MISC_ALLOC;
   wire alloc_range = bus_i.addr[7:4] == ADDR_QUEUE_ALLOC0[7:4];
   wire [1:0] alloc_idx = bus_i.addr[3:2];
   wire wr_qalloc   = bus_i.wr && alloc_range && bus_i.addr[1:0] == 2'b00;

   wire msix  = gen_cfg[CFG_MULTI_BIT];
   wire nsicr = gen_cfg[CFG_NSICR_BIT];
   wire [31:0] ext_valid = msix ? EXT_VALID_MSIX : EXT_VALID_LEGACY;

   // Legacy cause register and its summary
   wire [LEG_W-1:0] leg_set    = cause_i.other | (wr_lcset ? wd[LEG_W-1:0] : '0);
   wire             leg_active = |(leg_cause & leg_mask);
   wire             leg_new    = |(leg_set & (leg_mask | (wr_lmset ? wd[LEG_W-1:0] : '0)));
   // Clear-on-read is held back while the mask is non-zero and no unmasked cause is active, unless nsicr is set
   wire leg_rd_ok  = nsicr || leg_mask == '0 || leg_active;
   wire leg_iam_ok = nsicr || leg_active;
   wire [LEG_W-1:0] leg_clr = (wr_lcause ? wd[LEG_W-1:0] : '0)
                            | (rd_lcause && leg_rd_ok ? {LEG_W{1'b1}} : '0);
   wire [LEG_W-1:0] leg_mclr = (wr_lmclr ? wd[LEG_W-1:0] : '0)
                            | ((rd_lcause || wr_lcause) && leg_iam_ok
                               ? leg_auto_mask : '0);

   // Entry table: Rx i at 2i, Tx i at 2i+1, timer 8, other 9
   logic [ENTRY_W-1:0] entry [NUM_ENTRY];
   always_comb begin
      for (int i = 0; i < NUM_Q; i++) begin
         entry[2*i]   = queue_alloc[i][ENTRY_W-1:0];
         entry[2*i+1] = queue_alloc[i][ALLOC_W-1:ENTRY_W];
      end
      entry[2*NUM_Q]   = misc_alloc[ENTRY_W-1:0];
      entry[2*NUM_Q+1] = misc_alloc[ALLOC_W-1:ENTRY_W];
   end

   // Hardware cause steering onto extended cause bits
   logic [31:0] hw_set;
   always_comb begin
      hw_set = RST_WORD;
      for (int i = 0; i < NUM_Q; i++) begin
         if (cause_i.rx[i]) begin
            hw_set = hw_set | entry_bit(entry[2*i], msix);
         end
         if (cause_i.tx[i]) begin
            hw_set = hw_set | entry_bit(entry[2*i+1], msix);
         end
      end
      if (msix) begin
         if (cause_i.timer) begin
            hw_set = hw_set | entry_bit(entry[2*NUM_Q], 1'b1);
         end
         if (leg_new) begin
            hw_set = hw_set | entry_bit(entry[2*NUM_Q+1], 1'b1);
         end
      end else begin
         hw_set[EXT_TIMER_BIT] = cause_i.timer;
         hw_set[EXT_OTHER_BIT] = leg_new || leg_active;
      end
   end

   // Message engine bookkeeping
   wire [NUM_VEC-1:0] live    = ext_cause[NUM_VEC-1:0] & ext_mask[NUM_VEC-1:0];
   wire [NUM_VEC-1:0] pending = live & ~vec_sent;
   wire               ack     = msg_ack_i && msg.valid;
   logic [31:0] ack_bit;
   always_comb begin
      ack_bit = RST_WORD;
      if (ack) begin
         ack_bit[msg.vector] = 1'b1;
      end
   end

   // Extended cause: hardware and software sets win over any clear
   wire [31:0] ext_set = (hw_set | (wr_ecset ? wd : RST_WORD)) & ext_valid;
   wire [31:0] ext_clr = (wr_ecause ? wd : RST_WORD)
                       | (rd_ecause && !msix ? ~RST_WORD : RST_WORD)
                       | (ack_bit & ext_auto_clr);
   assign next_ext_cause = ((ext_cause & ~ext_clr) | ext_set) & ext_valid;

   // Extended mask: set requests win over clears
   wire [31:0] emask_set = (wr_emset ? wd : RST_WORD)
                         | (wr_ecset ? wd & ext_auto_mask : RST_WORD);
   wire [31:0] emask_clr = (wr_emclr ? wd : RST_WORD)
                         | (rd_ecause || wr_ecause ? ext_auto_mask : RST_WORD)
                         | (ack_bit & ext_auto_mask);
   assign next_ext_mask = (ext_mask & ~emask_clr) | emask_set;

   assign next_leg_cause = (leg_cause & ~leg_clr) | leg_set;
   assign next_leg_mask  = (leg_mask & ~leg_mclr) | (wr_lmset ? wd[LEG_W-1:0] : '0);

   // A vector is re-armed only once its cause or mask has dropped
   assign next_vec_sent = msix ? ((vec_sent & live) | ack_bit[NUM_VEC-1:0]) : '0;

   always_comb begin
      next_msg = msg;
      if (!msix) begin
         next_msg = '0;
      end else if (ack) begin
         next_msg.valid = 1'b0;
      end else if (!msg.valid && pending != '0) begin
         next_msg.valid  = 1'b1;
         next_msg.vector = lowest(pending);
      end
   end

   // Read selection; unmapped addresses read as zero
   always_comb begin
      rd_mux = RST_WORD;
      unique case (bus_i.addr)
         ADDR_EXT_CAUSE:     rd_mux = ext_cause;
         ADDR_EXT_MASK_SET:  rd_mux = ext_mask;
         ADDR_EXT_AUTO_CLR:  rd_mux = ext_auto_clr;
         ADDR_EXT_AUTO_MASK: rd_mux = ext_auto_mask;
         ADDR_LEG_CAUSE:     rd_mux = DATA_W'(leg_cause);
         ADDR_LEG_MASK_SET:  rd_mux = DATA_W'(leg_mask);
         ADDR_LEG_AUTO_MASK: rd_mux = DATA_W'(leg_auto_mask);
         ADDR_GEN_CONFIG:    rd_mux = DATA_W'(gen_cfg);
         ADDR_MISC_ALLOC:    rd_mux = DATA_W'(misc_alloc);
         default: begin
            if (alloc_range && bus_i.addr[1:0] == 2'b00) begin
               rd_mux = DATA_W'(queue_alloc[alloc_idx]);
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_cause <= RST_WORD;
         ext_mask  <= RST_WORD;
         leg_cause <= '0;
         leg_mask  <= '0;
         vec_sent  <= '0;
         msg       <= '0;
         rdata     <= RST_WORD;
         irq       <= 1'b0;
      end else begin
         ext_cause <= next_ext_cause;
         ext_mask  <= next_ext_mask;
         leg_cause <= next_leg_cause;
         leg_mask  <= next_leg_mask;
         vec_sent  <= next_vec_sent;
         msg       <= next_msg;
         rdata     <= bus_i.rd ? rd_mux : RST_WORD;
         irq       <= !msix && (next_ext_cause & next_ext_mask) != RST_WORD;
      end
   end

   // Plain configuration storage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_auto_clr  <= RST_WORD;
         ext_auto_mask <= RST_WORD;
         leg_auto_mask <= '0;
         gen_cfg       <= RST_CFG;
         misc_alloc    <= RST_ALLOC;
         for (int i = 0; i < NUM_Q; i++) begin
            queue_alloc[i] <= RST_ALLOC;
         end
      end else begin
         if (wr_eaclr) begin
            ext_auto_clr <= wd;
         end
         if (wr_eamask) begin
            ext_auto_mask <= wd;
         end
         if (wr_lamask) begin
            leg_auto_mask <= wd[LEG_W-1:0];
         end
         if (wr_cfg) begin
            gen_cfg <= wd[CFG_W-1:0];
         end
         if (wr_misc) begin
            misc_alloc <= wd[ALLOC_W-1:0];
         end
         if (wr_qalloc) begin
            queue_alloc[alloc_idx] <= wd[ALLOC_W-1:0];
         end
      end
   end

   assign rdata_o = rdata;
   assign msg_o   = msg;
   assign irq_o   = irq;

endmodule // icm_cause_mapper

// [test/icm_cause_mapper_monitor.sv]
// Port-level checker for the interrupt cause mapper
`timescale 1ns/10ps
module icm_monitor (
   input wire logic                        clk_i,
   input wire logic                        rst_i,
   input wire icm_pkg::icm_bus_req_t       bus_i,
   input wire logic [icm_pkg::DATA_W-1:0]  rdata_o,
   input wire icm_pkg::icm_cause_t         cause_i,
   input wire logic                        msg_ack_i,
   input wire icm_pkg::icm_msg_t           msg_o,
   input wire logic                        irq_o
);
   import icm_pkg::*;
   logic       msix;
   logic [3:0] mask_wr;
   wire        cfg_wr   = bus_i.wr && bus_i.addr == ADDR_GEN_CONFIG;
   wire        cause_rd = bus_i.rd && bus_i.addr == ADDR_EXT_CAUSE;
   wire        mask_wr_hit = bus_i.wr && bus_i.addr == ADDR_EXT_MASK_SET;
   wire        mask_rd_hit = bus_i.rd && bus_i.addr == ADDR_EXT_MASK_SET;
   // Mode mirror, so rules can be split by signalling mode
   always_ff @(posedge clk_i) begin
      if (rst_i)
         msix <= 1'b0;
      else if (cfg_wr)
         msix <= bus_i.wdata[CFG_MULTI_BIT];
   end
   always_ff @(posedge clk_i) begin
      if (mask_wr_hit)
         mask_wr <= bus_i.wdata[3:0];
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_vector_range: assert property (msg_o.valid |-> msg_o.vector <= 3'h4)
      else $error("vector above four");
   a_msg_holds: assert property (msg_o.valid && !msg_ack_i && !cfg_wr |=> msg_o.valid && $stable(msg_o.vector))
      else $error("message dropped or changed before ack");
   a_ack_drops: assert property (msg_o.valid && msg_ack_i |=> !msg_o.valid)
      else $error("message still up after ack");
   a_legacy_nomsg: assert property (!msix && !$past(msix) |-> !msg_o.valid)
      else $error("vector message in legacy mode");
   a_msix_no_irq: assert property (msix && $past(msix) |-> !irq_o)
      else $error("single interrupt in vector mode");
   a_timer_bit: assert property (!msix && cause_i.timer ##1 cause_rd && !msix |=> rdata_o[EXT_TIMER_BIT])
      else $error("timer bit missing");
   a_legacy_bits: assert property (cause_rd && !msix |=> (rdata_o & ~EXT_VALID_LEGACY) == 32'h0)
      else $error("stray cause bit in legacy mode");
   a_msix_bits: assert property (cause_rd && msix |=> (rdata_o & ~EXT_VALID_MSIX) == 32'h0)
      else $error("stray cause bit in vector mode");
   a_mask_readback: assert property (mask_wr_hit ##[1:2] mask_rd_hit |=> (rdata_o[3:0] & mask_wr) == mask_wr)
      else $error("mask read lost set bits");
   c_msg_acked: cover property (msg_o.valid && msg_ack_i);
   c_irq_rise: cover property ($rose(irq_o));
   c_to_msix: cover property (cfg_wr ##1 msix);
endmodule // icm_monitor

bind icm_cause_mapper icm_monitor i_icm_monitor (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
   .rdata_o(rdata_o), .cause_i(cause_i), .msg_ack_i(msg_ack_i), .msg_o(msg_o), .irq_o(irq_o));

// [test/icm_msg_sink.sv]
// Host stand-in that takes vector messages and acknowledges them
`timescale 1ns/10ps
module icm_msg_sink (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire icm_pkg::icm_msg_t msg_i,
   input  wire logic [3:0]        delay_i,
   output logic                   ack_o,
   output logic [2:0]             vec_o,
   output logic [7:0]             cnt_o
);
   import icm_pkg::*;
   logic [3:0] wait_cnt;
   // One-cycle ack after delay_i idle cycles; a slow host stretches the message
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         wait_cnt <= 4'h0;
         cnt_o <= 8'h00;
         vec_o <= 3'h0;
      end else begin
         ack_o <= 1'b0;
         if (msg_i.valid && ack_o) begin
            cnt_o <= cnt_o + 8'h01;
            vec_o <= msg_i.vector;
            wait_cnt <= 4'h0;
         end else if (msg_i.valid && wait_cnt == delay_i)
            ack_o <= 1'b1;
         else if (msg_i.valid)
            wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule // icm_msg_sink

// [test/testbench.sv]
// Self-checking bench for the interrupt cause mapper
`timescale 1ns/10ps
module testbench;
   import icm_pkg::*;
   logic         clk_i;
   logic         rst_i;
   icm_bus_req_t bus;
   icm_cause_t   cause;
   icm_msg_t     msg;
   logic [31:0]  rdata;
   logic         ack;
   logic         irq;
   logic [3:0]   sink_delay;
   logic [2:0]   got_vec;
   logic [7:0]   got_cnt;
   logic [2:0]   idx [8];
   logic [31:0]  m, s, a;
   logic [2:0]   vr, vt;
   int           mismatches, checks_done, k;

   icm_cause_mapper i_icm_cause_mapper (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus),
      .rdata_o(rdata), .cause_i(cause), .msg_ack_i(ack), .msg_o(msg), .irq_o(irq));
   icm_msg_sink i_icm_msg_sink (.clk_i(clk_i), .rst_i(rst_i), .msg_i(msg),
      .delay_i(sink_delay), .ack_o(ack), .vec_o(got_vec), .cnt_o(got_cnt));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Bus tasks start right after an edge and leave one idle cycle behind
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus.wr <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
      bus <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus.rd <= 1'b0;
      #1 check($sformatf("read %h", ad), rdata, exp);
      @(posedge clk_i);
   endtask
   task automatic pulse(input icm_cause_t c);
      cause <= c;
      @(posedge clk_i);
      cause <= '0;
   endtask
   task automatic wait_msg(input logic [2:0] v);
      logic [7:0] n;
      n = got_cnt;
      repeat (60) if (got_cnt == n) begin
         @(posedge clk_i);
         #1;
      end
      check("message vector", {28'h0, got_cnt != n, got_vec}, {29'h1, v});
      @(posedge clk_i);
   endtask
   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   function automatic logic [31:0] bit_of(input int b);
      return 32'h1 << b;
   endfunction
   function automatic logic [31:0] entry_pair(input logic [2:0] lo, input logic [2:0] hi);
      return {16'h0, 5'h10, hi, 5'h10, lo};
   endfunction
   function automatic icm_cause_t q_cause(input int q);
      icm_cause_t c;
      c = '0;
      if (q % 2 == 1)
         c.tx[q / 2] = 1'b1;
      else
         c.rx[q / 2] = 1'b1;
      return c;
   endfunction

   initial begin
      repeat (3000) @(posedge clk_i);
      mismatches++;
      report_and_stop();
   end

   initial begin
      bus = '0;
      cause = '0;
      rst_i = 1'b1;
      sink_delay = 4'h0;
      mismatches = 0;
      checks_done = 0;
      void'($urandom(44314));
      do_reset();
      for (k = 0; k <= 8'h44; k += 4) rdc(8'(k), 32'h0);
      $display("test reset_values done");
      foreach (idx[j]) idx[j] = 3'($urandom_range(0, 7));
      idx[0] = 3'h4;
      idx[1] = 3'h7;
      for (k = 0; k < 4; k++) wr(ADDR_QUEUE_ALLOC0 + 8'(4 * k), entry_pair(idx[2*k], idx[2*k+1]));
      wr(ADDR_MISC_ALLOC, 32'h00008181);
      for (k = 0; k < 8; k++) begin
         pulse(q_cause(k));
         rdc(ADDR_EXT_CAUSE, bit_of(idx[k][1:0]));
      end
      pulse('{rx: 4'h0, tx: 4'h0, timer: 1'b1, other: 16'h0});
      rdc(ADDR_EXT_CAUSE, bit_of(EXT_TIMER_BIT));
      $display("test legacy_steering done");
      k = $urandom_range(0, 15);
      m = bit_of(k);
      wr(ADDR_LEG_MASK_SET, m);
      wr(ADDR_LEG_AUTO_MASK, m);
      pulse('{rx: 4'h0, tx: 4'h0, timer: 1'b0, other: m[15:0]});
      rdc(ADDR_LEG_CAUSE, m);
      rdc(ADDR_LEG_MASK_SET, 32'h0);
      rdc(ADDR_EXT_CAUSE, bit_of(EXT_OTHER_BIT));
      wr(ADDR_LEG_CAUSE_SET, m);
      rdc(ADDR_LEG_CAUSE, m);
      $display("test legacy_other done");
      s = 32'($urandom_range(1, 15));
      a = 32'($urandom_range(0, 15));
      wr(ADDR_EXT_MASK_SET, s);
      rdc(ADDR_EXT_MASK_SET, s);
      wr(ADDR_EXT_MASK_CLR, s);
      rdc(ADDR_EXT_MASK_SET, 32'h0);
      wr(ADDR_EXT_AUTO_MASK, a);
      wr(ADDR_EXT_CAUSE_SET, s);
      check("irq", {31'h0, irq}, {31'h0, (s & a) != 0});
      rdc(ADDR_EXT_MASK_SET, s & a);
      rdc(ADDR_EXT_CAUSE, s);
      rdc(ADDR_EXT_MASK_SET, 32'h0);
      $display("test mask_and_set done");
      do_reset();
      wr(ADDR_GEN_CONFIG, 32'h10);
      vr = 3'($urandom_range(0, 4));
      vt = 3'($urandom_range(0, 4));
      wr(ADDR_QUEUE_ALLOC0, entry_pair(vr, 3'h0));
      wr(ADDR_MISC_ALLOC, entry_pair(vt, 3'h4));
      wr(ADDR_EXT_MASK_SET, 32'h1F);
      wr(ADDR_LEG_MASK_SET, 32'h1);
      sink_delay <= 4'($urandom_range(0, 7));
      pulse(q_cause(0));
      wait_msg(vr);
      rdc(ADDR_EXT_CAUSE, bit_of(vr));
      wr(ADDR_EXT_CAUSE, bit_of(vr));
      wr(ADDR_EXT_AUTO_CLR, 32'h1F);
      pulse('{rx: 4'h0, tx: 4'h0, timer: 1'b1, other: 16'h0});
      wait_msg(vt);
      rdc(ADDR_EXT_CAUSE, 32'h0);
      pulse('{rx: 4'h0, tx: 4'h0, timer: 1'b0, other: 16'h1});
      wait_msg(3'h4);
      rdc(ADDR_LEG_CAUSE, 32'h1);
      rdc(ADDR_EXT_CAUSE, 32'h0);
      wr(ADDR_EXT_AUTO_MASK, bit_of(vr));
      pulse(q_cause(0));
      wait_msg(vr);
      rdc(ADDR_EXT_MASK_SET, 32'h1F & ~bit_of(vr));
      $display("test vector_mode done");
      report_and_stop();
   end
endmodule // testbench
